// *** verilog/loopback_select_pkg.sv ***
package loopback_select_pkg;

    // =========================================================
    // Register map, word aligned byte addresses.
    localparam logic [4:0] MISC_CTRL_OFS = 5'h00;
    localparam logic [4:0] HOST_BUS_OFS = 5'h04;
    localparam logic [4:0] MISC_READ_OFS = 5'h08;
    localparam logic [4:0] IRQ_STATUS_OFS = 5'h0C;
    localparam logic [4:0] IRQ_ENABLE_OFS = 5'h10;
    localparam logic [4:0] IRQ_CLEAR_OFS = 5'h14;
    localparam logic [4:0] GAP_CTRL_OFS = 5'h18;

    // =========================================================
    // Miscellaneous control field positions.
    localparam int CTL_SELFTEST_LAMP = 0;
    localparam int CTL_HOST_INIT_LAMP = 1;
    localparam int CTL_LOOPBACK_SELECT = 2;
    localparam int CTL_GAP_TEST_ROUTE = 3;
    localparam int CTL_TEST_CLOCK_STROKE = 4;
    localparam int CTL_WRITE_GATE = 5;
    localparam int CTL_ERASE = 6;
    localparam int CTL_WIDTH = 7;
    // Both lamps lit, everything else off.
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 7'h03;

    // Host bus field, miscellaneous read fields.
    localparam int HOST_IRQ_BIT = 0;
    localparam int RD_WRITE_GATE = 0;
    localparam int RD_ERASE = 1;
    localparam int RD_HOST_IRQ = 2;
    localparam int RD_GAP_DETECTED = 3;
    localparam int RD_LOOPBACK = 4;

    // Interrupt status fields.
    localparam int EV_GAP_FALL = 0;
    localparam int EV_GAP_RISE = 1;
    localparam int EV_WIDTH = 2;

    // Gap control: write one to restart counter and flip-flop.
    localparam int GAP_CLEAR_BIT = 0;

    // =========================================================
    // Timing counts.
    localparam int GAP_STROKES = 8;

    // =========================================================
    // Types.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic data_rx;
        logic cmd_rx;
        logic tx_clk;
        logic rx_clk;
    } ser_in_t;

    typedef struct packed {
        logic rd_data;
        logic status;
        logic rd_clk;
        logic wr_clk;
        logic data_tx;
        logic cmd_tx;
    } pin_sample_t;

endpackage

// *** verilog/gap_counter.sv ***
`timescale 1ns/1ps
module gap_counter
    import loopback_select_pkg::*;
#(
    parameter int STROKES = GAP_STROKES
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic stroke_i,
    input wire logic restart_i,
    input wire logic clear_i,
    output logic gap_detected_o
);

    // =========================================================
    // Counter and gap flip-flop.
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_gap;

    always_comb begin
        next_count = count;
        next_gap = gap_detected_o;
        if (clear_i) begin
            // An eighth stroke landing with the clear still sets the gap.
            next_count = 4'h0;
            next_gap = stroke_i && !restart_i && !gap_detected_o
                && count == 4'(STROKES - 1);
        end else if (restart_i) begin
            // Activity on the source restarts the count only.
            next_count = 4'h0;
        end else if (stroke_i && !gap_detected_o) begin
            if (count == 4'(STROKES - 1)) begin
                next_gap = 1'b1;
                next_count = 4'h0;
            end else begin
                next_count = count + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= 4'h0;
            gap_detected_o <= 1'b0;
        end else begin
            count <= next_count;
            gap_detected_o <= next_gap;
        end
    end

    // =========================================================
    // Checks.
    a_gap_eighth_stroke: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        $rose(gap_detected_o) |-> $past(count) == 4'(STROKES - 1)
            && $past(stroke_i))
        else $error("Gap set on a stroke other than the eighth.");

    a_gap_holds_set: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        gap_detected_o && !clear_i |=> gap_detected_o)
        else $error("Gap flip-flop dropped without a clear.");

endmodule

// *** verilog/loopback_select_loopback.sv ***
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module loopback_select_loopback
    import loopback_select_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic data_chan_tx_i,
    input wire logic cmd_chan_tx_i,
    output logic data_chan_rx_o,
    output logic cmd_chan_rx_o,
    output logic ser_tx_clk_o,
    output logic ser_rx_clk_o,
    output logic gap_detect_n_o,
    input wire logic drive_rd_data_i,
    input wire logic drive_status_i,
    input wire logic drive_rd_clk_i,
    input wire logic drive_wr_clk_i,
    output logic drive_wr_data_o,
    output logic drive_cmd_o,
    output logic drive_write_gate_o,
    output logic drive_erase_o,
    output logic selftest_lamp_o,
    output logic host_init_lamp_o,
    output logic host_irq_request_o,
    output logic irq_o
);

    // =========================================================
    // Pin synchronisers; only stage two is read by logic.
    pin_sample_t pin_raw;
    pin_sample_t pin_meta;
    pin_sample_t pin_sync;

    assign pin_raw = '{rd_data: drive_rd_data_i, status: drive_status_i,
                       rd_clk: drive_rd_clk_i, wr_clk: drive_wr_clk_i,
                       data_tx: data_chan_tx_i, cmd_tx: cmd_chan_tx_i};

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // =========================================================
    // Avalon slave handshake: one wait cycle, then the answer.
    bus_state_t bus_state;
    bus_state_t next_bus_state;
    logic bus_req;
    logic bus_take;
    logic wr_take;

    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && (bus_state != BUS_ACK);
    assign bus_take = bus_req && (bus_state == BUS_ACK);
    assign wr_take = bus_take && avs_write;

    always_comb begin
        case (bus_state)
            BUS_IDLE: begin
                next_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
            end
            BUS_ACK: begin
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_state <= BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // =========================================================
    // Software registers.
    logic [CTL_WIDTH-1:0] misc_ctrl;
    logic [CTL_WIDTH-1:0] next_misc_ctrl;
    logic host_irq_request;
    logic next_host_irq_request;
    logic [EV_WIDTH-1:0] irq_status;
    logic [EV_WIDTH-1:0] next_irq_status;
    logic [EV_WIDTH-1:0] irq_enable;
    logic [EV_WIDTH-1:0] next_irq_enable;
    logic [EV_WIDTH-1:0] events;
    logic gap_clear;
    logic [31:0] next_readdata;
    logic gap_detected;

    // Lamps, write gate and erase are only what software last wrote:
    // the self-test and host init sequencing live in firmware.
    always_comb begin
        next_misc_ctrl = misc_ctrl;
        next_host_irq_request = host_irq_request;
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        gap_clear = 1'b0;
        if (wr_take) begin
            case (avs_address)
                MISC_CTRL_OFS: begin
                    next_misc_ctrl = avs_writedata[CTL_WIDTH-1:0];
                end
                HOST_BUS_OFS: begin
                    next_host_irq_request = avs_writedata[HOST_IRQ_BIT];
                end
                IRQ_ENABLE_OFS: begin
                    next_irq_enable = avs_writedata[EV_WIDTH-1:0];
                end
                IRQ_CLEAR_OFS: begin
                    next_irq_status = irq_status
                        & ~avs_writedata[EV_WIDTH-1:0];
                end
                GAP_CTRL_OFS: begin
                    gap_clear = avs_writedata[GAP_CLEAR_BIT];
                end
                default: begin
                    next_misc_ctrl = misc_ctrl;
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        next_irq_status = next_irq_status | events;
    end

    // Miscellaneous readback takes write gate, erase and host request from the driven lines.
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            MISC_CTRL_OFS: begin
                next_readdata[CTL_WIDTH-1:0] = misc_ctrl;
            end
            HOST_BUS_OFS: begin
                next_readdata[HOST_IRQ_BIT] = host_irq_request;
            end
            MISC_READ_OFS: begin
                next_readdata[RD_WRITE_GATE] = drive_write_gate_o;
                next_readdata[RD_ERASE] = drive_erase_o;
                next_readdata[RD_HOST_IRQ] = host_irq_request_o;
                next_readdata[RD_GAP_DETECTED] = gap_detected;
                next_readdata[RD_LOOPBACK] =
                    misc_ctrl[CTL_LOOPBACK_SELECT];
            end
            IRQ_STATUS_OFS: begin
                next_readdata[EV_WIDTH-1:0] = irq_status;
            end
            IRQ_ENABLE_OFS: begin
                next_readdata[EV_WIDTH-1:0] = irq_enable;
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            misc_ctrl <= CTL_RESET;
            host_irq_request <= 1'b0;
            irq_enable <= '0;
            irq_status <= '0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            misc_ctrl <= next_misc_ctrl;
            host_irq_request <= next_host_irq_request;
            irq_enable <= next_irq_enable;
            irq_status <= next_irq_status;
            if (avs_read && bus_state == BUS_IDLE) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    assign selftest_lamp_o = misc_ctrl[CTL_SELFTEST_LAMP];
    assign host_init_lamp_o = misc_ctrl[CTL_HOST_INIT_LAMP];
    assign drive_write_gate_o = misc_ctrl[CTL_WRITE_GATE];
    assign drive_erase_o = misc_ctrl[CTL_ERASE];
    assign host_irq_request_o = host_irq_request;
    assign irq_o = |(irq_status & irq_enable);

    // =========================================================
    // Loopback multiplexer, registered toward the serial chip.
    // Drive clock paths gain three cycles of latency, the test clock one; the test clock is
    // a register bit, so it runs far slower than a drive clock.
    logic loop_sel;
    logic test_clk;
    ser_in_t ser_in;
    ser_in_t next_ser_in;
    logic gap_src;
    logic gap_src_last;
    logic next_gap_src;
    logic rx_src;
    logic rx_src_last;
    logic drv_wr_data;
    logic drv_cmd;

    assign loop_sel = misc_ctrl[CTL_LOOPBACK_SELECT];
    assign test_clk = misc_ctrl[CTL_TEST_CLOCK_STROKE];

    always_comb begin
        if (loop_sel) begin
            next_ser_in.data_rx = pin_sync.data_tx;
            next_ser_in.cmd_rx = pin_sync.cmd_tx;
            next_ser_in.tx_clk = test_clk;
            next_ser_in.rx_clk = test_clk;
        end else begin
            next_ser_in.data_rx = pin_sync.rd_data;
            next_ser_in.cmd_rx = pin_sync.status;
            next_ser_in.tx_clk = pin_sync.wr_clk;
            next_ser_in.rx_clk = pin_sync.rd_clk;
        end
        next_gap_src = misc_ctrl[CTL_GAP_TEST_ROUTE]
            ? test_clk : pin_sync.rd_clk;
    end

    // The command channel needs only its data lines (asynchronous);
    // the data channel is given both clocks (synchronous).
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ser_in <= '0;
            gap_src <= 1'b0;
            gap_src_last <= 1'b0;
            rx_src_last <= 1'b0;
            drv_wr_data <= 1'b0;
            drv_cmd <= 1'b0;
        end else begin
            ser_in <= next_ser_in;
            gap_src <= next_gap_src;
            gap_src_last <= gap_src;
            rx_src_last <= rx_src;
            drv_wr_data <= pin_sync.data_tx;
            drv_cmd <= pin_sync.cmd_tx;
        end
    end

    assign rx_src = ser_in.data_rx;
    assign data_chan_rx_o = ser_in.data_rx;
    assign cmd_chan_rx_o = ser_in.cmd_rx;
    assign ser_tx_clk_o = ser_in.tx_clk;
    assign ser_rx_clk_o = ser_in.rx_clk;
    assign drive_wr_data_o = drv_wr_data;
    assign drive_cmd_o = drv_cmd;

    // =========================================================
    // Gap detection and its events.
    logic gap_stroke;
    logic gap_restart;
    logic gap_last;

    assign gap_stroke = gap_src && !gap_src_last;
    assign gap_restart = rx_src != rx_src_last;

    gap_counter #(
        .STROKES(GAP_STROKES)
    ) u_gap (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .stroke_i(gap_stroke),
        .restart_i(gap_restart),
        .clear_i(gap_clear),
        .gap_detected_o(gap_detected)
    );

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap_last <= 1'b0;
        end else begin
            gap_last <= gap_detected;
        end
    end

    // The gap signal toward the serial chip is active low.
    assign gap_detect_n_o = !gap_detected;
    assign events[EV_GAP_FALL] = gap_detected && !gap_last;
    assign events[EV_GAP_RISE] = !gap_detected && gap_last;

    // =========================================================
    // Checks.
    sequence s_ctrl_write;
        wr_take && avs_address == MISC_CTRL_OFS;
    endsequence

    a_lamp_write_follows: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_ctrl_write |=> selftest_lamp_o == $past(avs_writedata[0])
            && host_init_lamp_o == $past(avs_writedata[1]))
        else $error("Lamps do not follow the control write.");

    a_lamp_stays_lit: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        host_init_lamp_o && !(wr_take && avs_address == MISC_CTRL_OFS)
        |=> host_init_lamp_o)
        else $error("Lamp went out without a control write.");

    a_readback_lines: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        avs_read && avs_address == MISC_READ_OFS
            && bus_state == BUS_IDLE
        |=> avs_readdata[2:0] == {host_irq_request_o, drive_erase_o,
            drive_write_gate_o})
        else $error("Miscellaneous read does not show driven lines.");

    a_loop_data_route: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        $past(loop_sel) |-> data_chan_rx_o == $past(pin_sync.data_tx)
            && cmd_chan_rx_o == $past(pin_sync.cmd_tx))
        else $error("Loopback does not return transmit data.");

    a_loop_clock_route: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        $past(loop_sel) |-> ser_tx_clk_o == $past(test_clk)
            && ser_rx_clk_o == $past(test_clk))
        else $error("Loopback does not supply the test clock.");

    a_normal_pass: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !$past(loop_sel) |-> data_chan_rx_o == $past(pin_sync.rd_data)
            && cmd_chan_rx_o == $past(pin_sync.status)
            && ser_rx_clk_o == $past(pin_sync.rd_clk))
        else $error("Drive signals not passed in normal mode.");

    a_gap_event_irq: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        $fell(gap_detect_n_o) && irq_enable[EV_GAP_FALL] |=> irq_o
            && irq_status[EV_GAP_FALL])
        else $error("Gap falling edge did not raise an interrupt.");

    a_bus_one_wait: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        bus_req && bus_state == BUS_IDLE |=> !avs_waitrequest)
        else $error("Bus answer not given after one wait cycle.");

    a_test_to_gap: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        misc_ctrl[CTL_GAP_TEST_ROUTE] |=> gap_src == $past(test_clk))
        else $error("Test clock not routed to the gap counter.");

endmodule

// *** tb/serial_far_end.sv ***
`timescale 1ns/1ps
// ============================================================
// Far side: serial chip transmitters and the drive cable.
module serial_far_end (
    input wire logic clock_i,
    input wire logic frame_i,
    input wire logic tx_hold_i,
    output logic data_tx_o,
    output logic cmd_tx_o,
    output logic rd_data_o,
    output logic status_o,
    output logic rd_clk_o,
    output logic wr_clk_o
);
    // Drive clocks stand still outside frames; the odd phase keeps
    // their edges away from the board clock edges.
    initial begin
        rd_clk_o = 1'b0;
        wr_clk_o = 1'b0;
        data_tx_o = 1'b0;
        cmd_tx_o = 1'b1;
        rd_data_o = 1'b0;
        status_o = 1'b0;
        #7;
        forever begin
            #100;
            if (frame_i) rd_clk_o = ~rd_clk_o;
            #100;
            if (frame_i) wr_clk_o = ~wr_clk_o;
        end
    end
    always @(posedge clock_i) begin
        if (tx_hold_i) begin
            data_tx_o <= 1'b0;
            cmd_tx_o <= 1'b1;
        end else begin
            data_tx_o <= 1'($urandom_range(1, 0));
            cmd_tx_o <= 1'($urandom_range(1, 0));
        end
        // A released cable line is shown changing, never holding.
        if (frame_i) begin
            rd_data_o <= 1'($urandom_range(1, 0));
            status_o <= 1'($urandom_range(1, 0));
        end else begin
            rd_data_o <= ~rd_data_o;
            status_o <= ~status_o;
        end
    end
endmodule

// *** tb/tb_loopback_select_loopback.sv ***
`timescale 1ns/1ps
module tb_loopback_select_loopback
    import loopback_select_pkg::*;
;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic [2:0] r;
    logic avs_waitrequest, data_rx, cmd_rx, tx_clk, rx_clk, gap_n;
    logic wr_data, cmd, wgate, erase, lamp1, lamp2, hirq, irq;
    logic d_tx, c_tx, rd_d, st, rd_c, wr_c;
    logic frame = 1'b0;
    logic tx_hold = 1'b1;
    logic chk_en = 1'b0;
    logic lb = 1'b0;
    int errors = 0;
    int n_checks = 0;
    pin_sample_t hist [3];

    always #25 clock_i = ~clock_i;

    loopback_select_loopback DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .data_chan_tx_i(d_tx), .cmd_chan_tx_i(c_tx),
        .data_chan_rx_o(data_rx), .cmd_chan_rx_o(cmd_rx),
        .ser_tx_clk_o(tx_clk), .ser_rx_clk_o(rx_clk),
        .gap_detect_n_o(gap_n), .drive_rd_data_i(rd_d),
        .drive_status_i(st), .drive_rd_clk_i(rd_c),
        .drive_wr_clk_i(wr_c), .drive_wr_data_o(wr_data),
        .drive_cmd_o(cmd), .drive_write_gate_o(wgate),
        .drive_erase_o(erase), .selftest_lamp_o(lamp1),
        .host_init_lamp_o(lamp2), .host_irq_request_o(hirq),
        .irq_o(irq));

    serial_far_end far (.clock_i(clock_i), .frame_i(frame),
        .tx_hold_i(tx_hold), .data_tx_o(d_tx), .cmd_tx_o(c_tx),
        .rd_data_o(rd_d), .status_o(st), .rd_clk_o(rd_c),
        .wr_clk_o(wr_c));

    // ============================================================
    // Expectations and comparisons.
    function automatic logic exp_drx(pin_sample_t s, logic l);
        return l ? s.data_tx : s.rd_data;
    endfunction
    function automatic logic exp_crx(pin_sample_t s, logic l);
        return l ? s.cmd_tx : s.status;
    endfunction
    task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ============================================================
    // Register bus master.
    // A slave that never answers is caught by the watchdog.
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge clock_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        bus(1'b1, a, d);
        repeat (3) @(posedge clock_i);
    endtask
    task automatic set_mode(logic [31:0] ctl);
        chk_en = 1'b0;
        wr(MISC_CTRL_OFS, ctl);
        lb = ctl[CTL_LOOPBACK_SELECT];
        repeat (5) @(posedge clock_i);
        chk_en = 1'b1;
    endtask
    task automatic stroke(int k);
        repeat (k) begin
            wr(MISC_CTRL_OFS, 32'h1C);
            wr(MISC_CTRL_OFS, 32'h0C);
        end
    endtask

    // ============================================================
    // Pin stream: every output checked here trails its pin by three edges; gap_n is not checked here.
    always @(posedge clock_i) begin
        hist[0] <= {rd_d, st, rd_c, wr_c, d_tx, c_tx};
        hist[1] <= hist[0];
        hist[2] <= hist[1];
    end
    always @(negedge clock_i) begin
        if (chk_en) begin
            chk_pin("wr_data", hist[2].data_tx, wr_data);
            chk_pin("cmd", hist[2].cmd_tx, cmd);
            chk_pin("data_rx", exp_drx(hist[2], lb), data_rx);
            chk_pin("cmd_rx", exp_crx(hist[2], lb), cmd_rx);
            if (!lb) begin
                chk_pin("tx_clk", hist[2].wr_clk, tx_clk);
                chk_pin("rx_clk", hist[2].rd_clk, rx_clk);
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        errors++;
        $display("ERROR watchdog expected done seen timeout");
        end_sim();
    end

    // ============================================================
    // Main sequence.
    initial begin
        void'($urandom(32'h67578300));
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk_pin("lamp1", 1'b1, lamp1);
        chk_pin("lamp2", 1'b1, lamp2);
        chk_pin("gap_n", 1'b1, gap_n);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk_reg("reset_reg", (i == 0) ? 32'h3 : 32'h0, q);
        end
        wr(5'h1C, 32'hFFFF);
        bus(1'b0, 5'h1C, 32'h0);
        chk_reg("unmapped", 32'h0, q);
        wr(MISC_CTRL_OFS, 32'h2);
        chk_pin("lamp1", 1'b0, lamp1);
        chk_pin("lamp2", 1'b1, lamp2);
        wr(MISC_CTRL_OFS, 32'h0);
        chk_pin("lamp2", 1'b0, lamp2);
        for (int i = 0; i < 16; i++) begin
            r = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
            wr(MISC_CTRL_OFS, {25'h0, r[1:0], 5'h0});
            wr(HOST_BUS_OFS, {31'h0, r[2]});
            bus(1'b0, MISC_READ_OFS, 32'h0);
            chk_reg("misc_read", {29'h0, r}, q);
            chk_pin("write_gate", r[0], wgate);
            chk_pin("erase", r[1], erase);
            chk_pin("host_irq", r[2], hirq);
        end
        wr(HOST_BUS_OFS, 32'h0);
        frame <= 1'b1;
        tx_hold <= 1'b0;
        set_mode(32'h0);
        repeat (200) @(posedge clock_i);
        set_mode(32'h4);
        bus(1'b0, MISC_READ_OFS, 32'h0);
        chk_reg("misc_read", 32'h10, q);
        repeat (200) @(posedge clock_i);
        for (int t = 1; t >= 0; t--) begin
            wr(MISC_CTRL_OFS, 32'h4 | (32'(t) << 4));
            chk_pin("tx_clk", 1'(t), tx_clk);
            chk_pin("rx_clk", 1'(t), rx_clk);
        end
        // Held transmit keeps the looped data quiet, so only the
        // test clock strokes advance the gap count.
        tx_hold <= 1'b1;
        set_mode(32'h0C);
        wr(IRQ_ENABLE_OFS, 32'h1);
        wr(GAP_CTRL_OFS, 32'h1);
        wr(IRQ_CLEAR_OFS, 32'h3);
        stroke(5);
        tx_hold <= 1'b0;
        repeat (12) @(posedge clock_i);
        tx_hold <= 1'b1;
        repeat (6) @(posedge clock_i);
        stroke(7);
        chk_pin("gap_n", 1'b1, gap_n);
        chk_pin("irq", 1'b0, irq);
        stroke(1);
        chk_pin("gap_n", 1'b0, gap_n);
        bus(1'b0, IRQ_STATUS_OFS, 32'h0);
        chk_reg("irq_status", 32'h1, q);
        chk_pin("irq", 1'b1, irq);
        wr(IRQ_CLEAR_OFS, 32'h1);
        chk_pin("irq", 1'b0, irq);
        wr(GAP_CTRL_OFS, 32'h1);
        chk_pin("gap_n", 1'b1, gap_n);
        bus(1'b0, IRQ_STATUS_OFS, 32'h0);
        chk_reg("irq_status", 32'h2, q);
        chk_pin("irq", 1'b0, irq);
        wr(IRQ_ENABLE_OFS, 32'h3);
        chk_pin("irq", 1'b1, irq);
        wr(IRQ_CLEAR_OFS, 32'h3);
        chk_pin("irq", 1'b0, irq);
        end_sim();
    end
endmodule
